// ### src/sac_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_RESULT_ADDR      8'hd0
`define SAC_CONTROL_ADDR     8'hd1
`define SAC_CONTROL_RESET    8'h40
`define SAC_BIT_IRQ_EN       7
`define SAC_BIT_DONE         6
`define SAC_BIT_TRIGGER      5
`define SAC_BIT_POWER        4
`define SAC_OSC_DIV          4'd12
`define SAC_CONV_TIME_NS     70000
`define SAC_REF_OSC_NS       125
`define SAC_CONV_CYCLES      (`SAC_CONV_TIME_NS / `SAC_REF_OSC_NS)
`define SAC_SAMPLE_TICKS     7'd6
`define SAC_STEP_TICKS       7'd4
`define SAC_RESULT_BITS      8
`endif

// ### src/sac_pkg.sv
// Types shared by the converter control block
package sac_pkg;
    typedef enum logic [1:0]
    {
        SAC_IDLE   = 2'b00,
        SAC_SAMPLE = 2'b01,
        SAC_STEP   = 2'b10
    } sac_state_e;

    typedef struct packed
    {
        logic       sel;
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sac_bus_s;

    typedef struct packed
    {
        logic       irq_enable;
        logic       done;
        logic       power_on;
    } sac_ctrl_s;
endpackage

// ### src/sac_clk_div.sv
// Divide-by-twelve enable generator for the converter clock
`timescale 1ns/100ps
`include "sac_map.svh"
module sac_clk_div
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic restart,
    output logic      tick
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    always_comb
    begin
        cnt_d = cnt_q + 4'd1;
        if (restart || cnt_q == `SAC_OSC_DIV - 4'd1)
        begin
            cnt_d = 4'd0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cnt_q <= 4'd0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    assign tick = !restart && (cnt_q == `SAC_OSC_DIV - 4'd1);
endmodule

// ### src/sac_control.sv
// Successive-approximation converter control and register file
// Behaviour
// - 8-bit SAR, sequencer clocked at osc/12
// - One conversion lasts about 70 us
// - Trigger write starts and clears done flag
// - Completion sets done flag, result valid
// - One conversion per trigger, then idle
// - Trigger during conversion restarts conversion
// - Trigger bit always reads zero
// - Interrupt request when done and enabled
// - Bit 7 enables the done interrupt
// - Bit 6 read-only done flag
// - Bit 5 triggers on selected channel
// - Bit 4 powers converter; zero powers down
// - Keeps running through processor wait state
// - Reset aborts conversion, control becomes 40h
// - Result register read-only, latest result
`timescale 1ns/100ps
`include "sac_map.svh"
module sac_control
(
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire sac_pkg::sac_bus_s bus,
    output logic [7:0]           rdata,
    input  wire logic            comp_above,
    output logic [7:0]           dac_code,
    output logic                 sample_hold,
    output logic                 analog_power_on,
    output logic                 busy,
    output logic                 irq_req
);
    // ------------------------------------------------
    // Constants
    // ------------------------------------------------
    localparam int CONV_CYCLES = `SAC_CONV_CYCLES;
    localparam int CONV_LO = CONV_CYCLES - CONV_CYCLES / 10;
    localparam int CONV_HI = CONV_CYCLES + CONV_CYCLES / 10;
    localparam logic [6:0] LAST_SAMPLE_TICK = `SAC_SAMPLE_TICKS;
    localparam logic [6:0] LAST_STEP_TICK = `SAC_STEP_TICKS;

    // ------------------------------------------------
    // Register decode
    // ------------------------------------------------
    function automatic logic hit(input sac_pkg::sac_bus_s b, input logic [7:0] a);
        hit = b.sel && (b.addr == a);
    endfunction

    logic ctrl_wr;
    logic trig;
    assign ctrl_wr = bus.wr && hit(bus, `SAC_CONTROL_ADDR);
    assign trig    = ctrl_wr && bus.wdata[`SAC_BIT_TRIGGER];

    // ------------------------------------------------
    // State
    // ------------------------------------------------
    sac_pkg::sac_state_e state_q;
    sac_pkg::sac_state_e state_d;
    sac_pkg::sac_ctrl_s  ctrl_q;
    sac_pkg::sac_ctrl_s  ctrl_d;
    logic [7:0]          sar_q;
    logic [7:0]          sar_d;
    logic [7:0]          result_q;
    logic [7:0]          result_d;
    logic [2:0]          bit_q;
    logic [2:0]          bit_d;
    logic [6:0]          sub_q;
    logic [6:0]          sub_d;
    logic                tick;

    // Divider restarts with each trigger so steps align with the start
    sac_clk_div u_div
    (
        .clk     (clk),
        .resetn  (resetn),
        .restart (trig),
        .tick    (tick)
    );

    // ------------------------------------------------
    // Comparator synchroniser
    // ------------------------------------------------
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       comp_q;
    logic       comp_d;

    always_comb
    begin
        sync_d = {sync_q[1:0], comp_above};
        comp_d = comp_q;
        if (sync_q[2] == sync_q[1])
        begin
            comp_d = sync_q[2];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sync_q <= 3'h0;
            comp_q <= 1'b0;
        end
        else
        begin
            sync_q <= sync_d;
            comp_q <= comp_d;
        end
    end

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    always_comb
    begin
        state_d  = state_q;
        ctrl_d   = ctrl_q;
        sar_d    = sar_q;
        result_d = result_q;
        bit_d    = bit_q;
        sub_d    = sub_q;
        if (ctrl_wr)
        begin
            ctrl_d.irq_enable = bus.wdata[`SAC_BIT_IRQ_EN];
            ctrl_d.power_on   = bus.wdata[`SAC_BIT_POWER];
        end
        case (state_q)
            sac_pkg::SAC_IDLE:
            begin
                sar_d = sar_q;
            end
            sac_pkg::SAC_SAMPLE:
            begin
                if (tick)
                begin
                    sub_d = sub_q + 7'd1;
                    if (sub_q == LAST_SAMPLE_TICK)
                    begin
                        sub_d   = 7'd0;
                        state_d = sac_pkg::SAC_STEP;
                    end
                end
            end
            sac_pkg::SAC_STEP:
            begin
                // One bit decided per group of converter ticks, MSB first
                if (tick)
                begin
                    sub_d = sub_q + 7'd1;
                    if (sub_q == LAST_STEP_TICK)
                    begin
                        sub_d = 7'd0;
                        sar_d[bit_q] = !comp_q;
                        if (bit_q != 3'd0)
                        begin
                            sar_d[bit_q - 3'd1] = 1'b1;
                            bit_d = bit_q - 3'd1;
                        end
                        else
                        begin
                            result_d    = {sar_q[7:1], !comp_q};
                            ctrl_d.done = 1'b1;
                            state_d     = sac_pkg::SAC_IDLE;
                        end
                    end
                end
            end
            default:
            begin
                state_d = sac_pkg::SAC_IDLE;
            end
        endcase
        if (!ctrl_q.power_on)
        begin
            state_d = sac_pkg::SAC_IDLE;
        end
        if (trig)
        begin
            // Restart wins over completion in the same cycle
            ctrl_d.done = 1'b0;
            state_d     = sac_pkg::SAC_SAMPLE;
            sar_d       = 8'h80;
            bit_d       = 3'd7;
            sub_d       = 7'd0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_q  <= sac_pkg::SAC_IDLE;
            ctrl_q   <= '{irq_enable: 1'b0, done: 1'b1, power_on: 1'b0};
            sar_q    <= 8'h00;
            result_q <= 8'h00;
            bit_q    <= 3'd7;
            sub_q    <= 7'd0;
        end
        else
        begin
            state_q  <= state_d;
            ctrl_q   <= ctrl_d;
            sar_q    <= sar_d;
            result_q <= result_d;
            bit_q    <= bit_d;
            sub_q    <= sub_d;
        end
    end

    // ------------------------------------------------
    // Read mux
    // ------------------------------------------------
    always_comb
    begin
        rdata = 8'h00;
        if (bus.rd && hit(bus, `SAC_RESULT_ADDR))
        begin
            rdata = result_q;
        end
        else if (bus.rd && hit(bus, `SAC_CONTROL_ADDR))
        begin
            rdata = {ctrl_q.irq_enable, ctrl_q.done, 1'b0, ctrl_q.power_on, 4'h0};
        end
    end

    // ------------------------------------------------
    // Outputs
    // ------------------------------------------------
    assign dac_code        = sar_q;
    assign sample_hold     = (state_q == sac_pkg::SAC_SAMPLE);
    assign analog_power_on = ctrl_q.power_on;
    assign busy            = (state_q != sac_pkg::SAC_IDLE);
    assign irq_req         = ctrl_q.done && ctrl_q.irq_enable;

    // ------------------------------------------------
    // Conversion age, for the timing checks
    // ------------------------------------------------
    logic [10:0] age_q;
    logic [10:0] age_d;

    always_comb
    begin
        age_d = age_q;
        if (trig)
        begin
            age_d = 11'h000;
        end
        else if (busy && age_q != 11'h7ff)
        begin
            age_d = age_q + 11'h001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            age_q <= 11'h000;
        end
        else
        begin
            age_q <= age_d;
        end
    end

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    reset_value_a: assert property (@(posedge clk)
        !resetn |=> (ctrl_q.done && !ctrl_q.irq_enable && state_q == sac_pkg::SAC_IDLE))
        else $error("control reset value wrong");

    trigger_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        trig |=> (!ctrl_q.done && state_q == sac_pkg::SAC_SAMPLE))
        else $error("trigger did not clear done");

    trig_read_a: assert property (@(posedge clk) disable iff (!resetn)
        (bus.rd && hit(bus, `SAC_CONTROL_ADDR)) |-> (rdata[5] == 1'b0 && rdata[3:0] == 4'h0))
        else $error("write-only bits read nonzero");

    irq_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(irq_req) |-> ($past(ctrl_wr) || $past(state_q) == sac_pkg::SAC_STEP))
        else $error("irq raised without enable or completion");

    done_rises_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(ctrl_q.done) |-> ($past(state_q) == sac_pkg::SAC_STEP && $past(bit_q) == 3'd0))
        else $error("done set outside completion");

    conv_bound_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(ctrl_q.done) |-> (age_q >= CONV_LO && age_q <= CONV_HI))
        else $error("conversion time out of range");

    result_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        (busy && !$rose(ctrl_q.done)) |=> (result_q == $past(result_q) || ctrl_q.done))
        else $error("result changed mid conversion");

    power_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        (!ctrl_q.power_on && !trig) |=> (state_q == sac_pkg::SAC_IDLE))
        else $error("converter runs while powered down");

    single_conv_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == sac_pkg::SAC_IDLE && !trig) |=> (state_q == sac_pkg::SAC_IDLE))
        else $error("conversion started without trigger");

    ctrl_write_a: assert property (@(posedge clk) disable iff (!resetn)
        ctrl_wr |=> (ctrl_q.irq_enable == $past(bus.wdata[7])))
        else $error("enable bit not written");

    conv_limit_a: assert property (@(posedge clk) disable iff (!resetn)
        busy |-> (age_q <= CONV_HI))
        else $error("conversion runs too long");

    restart_load_a: assert property (@(posedge clk) disable iff (!resetn)
        trig |=> (sar_q == 8'h80 && bit_q == 3'd7 && sub_q == 7'd0))
        else $error("restart did not reload sequencer");

    msb_step_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == sac_pkg::SAC_STEP && tick && sub_q == LAST_STEP_TICK &&
        bit_q != 3'd0 && !trig) |=> (bit_q == $past(bit_q) - 3'd1))
        else $error("bit order not MSB first");

    done_fall_a: assert property (@(posedge clk) disable iff (!resetn)
        $fell(ctrl_q.done) |-> $past(trig))
        else $error("done cleared without trigger");

    result_stable_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q != sac_pkg::SAC_STEP) |=> $stable(result_q))
        else $error("result changed outside completion");
endmodule

// ### verif/sac_analog_src.sv
// Analog input pin and comparator model at the converter's far side
`timescale 1ns/100ps
module sac_analog_src
(
    input  wire logic       clk,
    input  wire logic [7:0] dac_code,
    input  wire logic [7:0] vin,
    input  wire logic       power_on,
    output logic            comp_above
);
    logic chatter_q = 1'b0;

    // Unpowered comparator output is meaningless, so it chatters
    always_ff @(posedge clk)
        chatter_q <= ~chatter_q;

    // One selected input only; high when input lies below the trial code
    assign comp_above = power_on ? (dac_code > vin) : chatter_q;
endmodule

// ### verif/sac_control_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`include "sac_map.svh"
module sac_control_test;
    logic              clk    = 1'b0;
    logic              resetn = 1'b0;
    sac_pkg::sac_bus_s bus    = '0;
    logic [7:0]        vin    = 8'h00;
    logic [7:0]        rdata;
    logic [7:0]        dac_code;
    logic              comp_above;
    logic              sample_hold;
    logic              analog_power_on;
    logic              busy;
    logic              irq_req;
    logic [7:0]        vals [3] = '{8'h00, 8'hff, 8'ha5};
    int                n_fail = 0;
    int                comparisons = 0;
    int                n;

    always #10 clk = ~clk;

    sac_control i_sac_control (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
        .comp_above(comp_above), .dac_code(dac_code), .sample_hold(sample_hold),
        .analog_power_on(analog_power_on), .busy(busy), .irq_req(irq_req));

    sac_analog_src i_sac_analog_src (.clk(clk), .dac_code(dac_code), .vin(vin),
        .power_on(analog_power_on), .comp_above(comp_above));

    // ------------------------------------------------------------
    // Bus, check and verdict tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{sel: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{sel: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        check(rdata, exp);
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic conv(input logic [7:0] v);
        wr(`SAC_CONTROL_ADDR, 8'hb0);
        rd(`SAC_CONTROL_ADDR, 8'h90);
        check({7'h00, irq_req}, 8'h00);
        check(dac_code, 8'h80);
        check({7'h00, sample_hold}, 8'h01);
        n = 2;
        while (busy !== 1'b0 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        check({7'h00, n >= `SAC_CONV_CYCLES * 9 / 10 && n <= `SAC_CONV_CYCLES * 11 / 10}, 8'h01);
        rd(`SAC_RESULT_ADDR, v);
        rd(`SAC_CONTROL_ADDR, 8'hd0);
        check({7'h00, irq_req}, 8'h01);
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        #(20 * 20000);
        n_fail++;
        give_verdict();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        rd(`SAC_CONTROL_ADDR, 8'h40);
        rd(`SAC_RESULT_ADDR, 8'h00);
        rd(8'hd5, 8'h00);
        wr(`SAC_CONTROL_ADDR, 8'h9f);
        rd(`SAC_CONTROL_ADDR, 8'hd0);
        check({7'h00, irq_req, analog_power_on}, 8'h03);
        foreach (vals[i])
        begin
            vin <= vals[i];
            conv(vals[i]);
        end
        repeat (300) @(negedge clk);
        check({7'h00, busy}, 8'h00);
        wr(`SAC_CONTROL_ADDR, 8'hb0);
        repeat (300) @(posedge clk);
        vin <= 8'h3c;
        conv(8'h3c);
        wr(`SAC_RESULT_ADDR, 8'h55);
        rd(`SAC_RESULT_ADDR, 8'h3c);
        wr(`SAC_CONTROL_ADDR, 8'hb0);
        repeat (50) @(posedge clk);
        wr(`SAC_CONTROL_ADDR, 8'h80);
        rd(`SAC_CONTROL_ADDR, 8'h80);
        repeat (1400) @(posedge clk);
        rd(`SAC_CONTROL_ADDR, 8'h80);
        check({6'h00, busy, analog_power_on}, 8'h00);
        wr(`SAC_CONTROL_ADDR, 8'h90);
        wr(`SAC_CONTROL_ADDR, 8'hb0);
        repeat (100) @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(`SAC_CONTROL_ADDR, 8'h40);
        check({6'h00, busy, irq_req}, 8'h00);
        give_verdict();
    end
endmodule
